// ---- core/cle_pkg.sv ----
// Constants, types and helpers shared by the console line editor
package cle_pkg;
  // Register byte offsets
  localparam logic [11:0] CLE_REG_CTRL = 12'h000;
  localparam logic [11:0] CLE_REG_CMD = 12'h004;
  localparam logic [11:0] CLE_REG_STAT = 12'h008;
  localparam logic [11:0] CLE_REG_TXD = 12'h00C;
  localparam logic [11:0] CLE_REG_LINE = 12'h040;
  localparam logic [3:0] CLE_CTRL_RST = 4'h0;
  // CTRL fields
  localparam int CLE_CTRL_VIDEO = 0;
  localparam int CLE_CTRL_HALTEN = 1;
  localparam int CLE_CTRL_PROGIO = 2;
  localparam int CLE_CTRL_BINLD = 3;
  // CMD fields (write one to act)
  localparam int CLE_CMD_PROMPT = 0;
  localparam int CLE_CMD_ERRMSG = 1;
  localparam int CLE_CMD_CLRABT = 2;
  localparam int CLE_CMD_RELEASE = 3;
  localparam int CLE_CMD_CLROVR = 4;
  // STAT fields
  localparam int CLE_ST_READY = 0;
  localparam int CLE_ST_NULL = 1;
  localparam int CLE_ST_LONG = 2;
  localparam int CLE_ST_BADCTL = 3;
  localparam int CLE_ST_ABORT = 4;
  localparam int CLE_ST_DISCARD = 5;
  localparam int CLE_ST_STOP = 6;
  localparam int CLE_ST_REPROMPT = 7;
  localparam int CLE_ST_OVR = 8;
  localparam int CLE_ST_TXBUSY = 9;
  localparam int CLE_ST_CNT = 16;
  // Line geometry
  localparam logic [6:0] CLE_LINE_MAX = 7'h50;
  localparam logic [6:0] CLE_LINE_LAST = CLE_LINE_MAX - 7'h01;
  localparam logic [6:0] CLE_CNT_SAT = 7'h7F;
  // Character codes
  localparam logic [7:0] CLE_CH_CR = 8'h0D;
  localparam logic [7:0] CLE_CH_LF = 8'h0A;
  localparam logic [7:0] CLE_CH_BS = 8'h08;
  localparam logic [7:0] CLE_CH_TAB = 8'h09;
  localparam logic [7:0] CLE_CH_SP = 8'h20;
  localparam logic [7:0] CLE_CH_DEL = 8'h7F;
  localparam logic [7:0] CLE_CH_BSL = 8'h5C;
  localparam logic [7:0] CLE_CH_GT = 8'h3E;
  localparam logic [7:0] CLE_CH_BANG = 8'h21;
  localparam logic [7:0] CLE_CH_CARET = 8'h5E;
  localparam logic [7:0] CLE_CTL_C = 8'h03;
  localparam logic [7:0] CLE_CTL_O = 8'h0F;
  localparam logic [7:0] CLE_CTL_Q = 8'h11;
  localparam logic [7:0] CLE_CTL_R = 8'h12;
  localparam logic [7:0] CLE_CTL_S = 8'h13;
  localparam logic [7:0] CLE_CTL_U = 8'h15;
  localparam logic [7:0] CLE_CARET_OFS = 8'h40;
  localparam logic [7:0] CLE_C0_END = 8'h20;
  localparam logic [7:0] CLE_C1_LO = 8'h80;
  localparam logic [7:0] CLE_C1_END = 8'hA0;

  typedef enum logic [1:0] {CLE_IDLE, CLE_ECHO, CLE_RETYPE} cle_state_t;

  // One glyph for the terminal; caret set means print as caret pair
  typedef struct packed {
    logic caret;
    logic [7:0] code;
  } cle_glyph_t;

  function automatic logic cle_is_ctl(input logic [7:0] c);
    return (c < CLE_C0_END) || (c >= CLE_C1_LO && c < CLE_C1_END);
  endfunction
endpackage

// ---- core/cle_emit.sv ----
// Terminal transmit stage: caret expansion and output stop
`timescale 1ns/100ps
`default_nettype none
module cle_emit (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Glyph in
  input wire logic in_valid_i,
  input wire cle_pkg::cle_glyph_t in_glyph_i,
  output logic in_ready_o,
  // Flow stop
  input wire logic hold_i,
  // Terminal out
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i
);
  import cle_pkg::*;

  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic sec_v_q;
  logic [7:0] sec_q;

  // Hold stops between bytes only; a caret pair may split across a stop
  assign in_ready_o = !tx_valid_q && !sec_v_q && !hold_i;
  assign tx_valid_o = tx_valid_q;
  assign tx_data_o = tx_data_q;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      sec_v_q <= 1'b0;
      sec_q <= 8'h00;
    end else if (tx_valid_q) begin
      if (tx_ready_i) begin
        tx_valid_q <= 1'b0;
      end
    end else if (!hold_i) begin
      if (sec_v_q) begin
        tx_data_q <= sec_q;
        tx_valid_q <= 1'b1;
        sec_v_q <= 1'b0;
      end else if (in_valid_i) begin
        tx_valid_q <= 1'b1;
        if (in_glyph_i.caret) begin
          tx_data_q <= CLE_CH_CARET;
          sec_q <= in_glyph_i.code + CLE_CARET_OFS;
          sec_v_q <= 1'b1;
        end else begin
          tx_data_q <= in_glyph_i.code;
        end
      end
    end
  end
endmodule // cle_emit
`default_nettype wire

// ---- core/cle_editor.sv ----
// Console line editor with APB register access
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Act only after CR; echo CR LF
// - Empty line is a valid null command
// - Hardcopy rubout echoes removed chars in backslashes
// - Video rubout erases the previous character
// - Rubout on empty line is ignored
// - Ctrl-C echoes caret-C and aborts, not in binload
// - Ctrl-C clears stop and output discard
// - Ctrl-O toggles discard; echo only when enabling
// - Prompt or error message re-enables output
// - Ctrl-S stops output, Ctrl-Q resumes, no echo
// - Ctrl-U echoes caret-U CR, drops line
// - Ctrl-R echoes CR LF and retypes line
// - Console mode break acts as Ctrl-C
// - Program mode break halts if halts enabled
// - Other controls echo as caret plus 64
// - Hardcopy rubbed-out controls echo in caret form; video rubout echoes BS SP BS
// - Controls stored; flagged unless inside comment
// - Lines over 80 characters are flagged
// - Whitespace collapsed, trimmed, tabs echo spaces
module cle_editor (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Terminal receive
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_break_i,
  // Terminal transmit
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // Processor halt request
  output logic halt_o
);
  import cle_pkg::*;

  logic [3:0] ctrl_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, rdata;
  logic hit, acc, wr_cmd, wr_txd;
  logic [9:0] widx;
  logic line_hit;
  logic [6:0] lidx;
  logic stop_q, ovr_q, pend_q, pend_brk_q;
  logic [7:0] pend_c_q;
  logic arr, took;
  cle_state_t state_q;
  logic [7:0] line_q [80];
  logic [6:0] cnt_q, rlim, ridx_q, cmt_q, ctl_cnt_q;
  logic cmt_v_q, rub_open_q, video_q, ready_q, null_q, long_q, bad_q;
  logic abort_q, discard_q, reprompt_q, halt_q, prm_q, txp_q, force_q, retype_q;
  logic [7:0] txb_q, rem_c;
  cle_glyph_t seq_q [4];
  logic [1:0] seq_n_q, seq_i_q;
  logic go, kabort, khalt, kedit, skip, adv, em_valid, em_ready;
  cle_glyph_t em_g;

  // APB: one wait state, answer registered
  assign acc = psel_i && penable_i && pready_q;
  assign wr_cmd = acc && pwrite_i && paddr_i == CLE_REG_CMD;
  assign wr_txd = acc && pwrite_i && paddr_i == CLE_REG_TXD;
  assign widx = paddr_i[11:2];
  assign line_hit = paddr_i[1:0] == 2'h0 && widx >= CLE_REG_LINE[11:2]
                    && widx < CLE_REG_LINE[11:2] + 10'(CLE_LINE_MAX);
  assign lidx = 7'(widx - CLE_REG_LINE[11:2]);

  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    if (paddr_i == CLE_REG_CTRL) begin
      rdata[3:0] = ctrl_q;
    end else if (paddr_i == CLE_REG_CMD || paddr_i == CLE_REG_TXD) begin
      rdata = 32'h0000_0000;
    end else if (paddr_i == CLE_REG_STAT) begin
      rdata[CLE_ST_READY] = ready_q;
      rdata[CLE_ST_NULL] = null_q;
      rdata[CLE_ST_LONG] = long_q;
      rdata[CLE_ST_BADCTL] = bad_q;
      rdata[CLE_ST_ABORT] = abort_q;
      rdata[CLE_ST_DISCARD] = discard_q;
      rdata[CLE_ST_STOP] = stop_q;
      rdata[CLE_ST_REPROMPT] = reprompt_q;
      rdata[CLE_ST_OVR] = ovr_q;
      rdata[CLE_ST_TXBUSY] = txp_q;
      rdata[CLE_ST_CNT +: 7] = cnt_q;
    end else if (line_hit) begin
      rdata[7:0] = line_q[lidx];
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel_i && penable_i && !pready_q;
      if (psel_i && penable_i && !pready_q) begin
        prdata_q <= pwrite_i ? 32'h0000_0000 : rdata;
        pslverr_q <= !hit;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= CLE_CTRL_RST;
    end else begin
      if (acc && pwrite_i && paddr_i == CLE_REG_CTRL) begin
        ctrl_q <= pwdata_i[3:0];
      end
      if (khalt && ctrl_q[CLE_CTRL_HALTEN]) begin
        ctrl_q[CLE_CTRL_PROGIO] <= 1'b0;
      end
    end
  end

  // Flow control acts on arrival so a stopped output can always restart
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stop_q <= 1'b0;
    end else if (rx_valid_i && !rx_break_i) begin
      if (rx_data_i == CLE_CTL_S) begin
        stop_q <= 1'b1;
      end else if (rx_data_i == CLE_CTL_Q) begin
        stop_q <= 1'b0;
      end else if (rx_data_i == CLE_CTL_C && !ctrl_q[CLE_CTRL_BINLD]) begin
        stop_q <= 1'b0;
      end
    end else if (rx_break_i && !ctrl_q[CLE_CTRL_PROGIO]) begin
      stop_q <= 1'b0;
    end
  end

  // One-character holding slot; no ready back to the receiver
  assign arr = rx_break_i || (rx_valid_i && rx_data_i != CLE_CTL_S
               && rx_data_i != CLE_CTL_Q
               && !(rx_data_i == CLE_CTL_C && ctrl_q[CLE_CTRL_BINLD]));

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_q <= 1'b0;
      pend_brk_q <= 1'b0;
      pend_c_q <= 8'h00;
      ovr_q <= 1'b0;
    end else begin
      if (arr && pend_q && !took) begin
        ovr_q <= 1'b1;
      end else if (wr_cmd && pwdata_i[CLE_CMD_CLROVR]) begin
        ovr_q <= 1'b0;
      end
      if (arr && (!pend_q || took)) begin
        pend_q <= 1'b1;
        pend_brk_q <= rx_break_i;
        pend_c_q <= rx_data_i;
      end else if (took) begin
        pend_q <= 1'b0;
      end
    end
  end

  assign go = state_q == CLE_IDLE && !prm_q && !txp_q && pend_q;
  assign kabort = go && (pend_brk_q ? !ctrl_q[CLE_CTRL_PROGIO]
                  : pend_c_q == CLE_CTL_C);
  assign khalt = go && pend_brk_q && ctrl_q[CLE_CTRL_PROGIO];
  assign kedit = go && !pend_brk_q && pend_c_q != CLE_CTL_C && !ready_q;
  assign took = kabort || khalt || kedit;
  assign rlim = (cnt_q > CLE_LINE_MAX) ? CLE_LINE_MAX : cnt_q;
  assign rem_c = (cnt_q > CLE_LINE_MAX) ? line_q[CLE_LINE_LAST] : line_q[cnt_q - 7'h01];

  always_comb begin
    em_valid = 1'b0;
    em_g = '0;
    skip = 1'b0;
    if (state_q == CLE_ECHO && seq_i_q != seq_n_q) begin
      if (discard_q && !force_q) begin
        skip = 1'b1;
      end else begin
        em_valid = 1'b1;
        em_g = seq_q[seq_i_q];
      end
    end else if (state_q == CLE_RETYPE && ridx_q != rlim) begin
      if (discard_q) begin
        skip = 1'b1;
      end else begin
        em_valid = 1'b1;
        em_g = '{caret: cle_is_ctl(line_q[ridx_q]), code: line_q[ridx_q]};
      end
    end
  end
  assign adv = skip || (em_valid && em_ready);

  // Line editing, echo sequencing and line state
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= CLE_IDLE;
      cnt_q <= 7'h00;
      ridx_q <= 7'h00;
      cmt_q <= 7'h00;
      ctl_cnt_q <= 7'h00;
      {cmt_v_q, rub_open_q, video_q, ready_q, null_q, long_q, bad_q} <= 7'h00;
      {abort_q, discard_q, reprompt_q, halt_q, prm_q, txp_q} <= 6'h00;
      {force_q, retype_q} <= 2'h0;
      txb_q <= 8'h00;
      seq_n_q <= 2'h0;
      seq_i_q <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        seq_q[i] <= '0;
      end
    end else begin
      halt_q <= khalt && ctrl_q[CLE_CTRL_HALTEN];
      if (wr_cmd && pwdata_i[CLE_CMD_PROMPT]) begin
        prm_q <= 1'b1;
      end
      if (wr_txd && !txp_q) begin
        txp_q <= 1'b1;
        txb_q <= pwdata_i[7:0];
      end
      if (wr_cmd && pwdata_i[CLE_CMD_ERRMSG]) begin
        discard_q <= 1'b0;
      end
      if (wr_cmd && pwdata_i[CLE_CMD_RELEASE]) begin
        ready_q <= 1'b0;
        cnt_q <= 7'h00;
        {cmt_v_q, ctl_cnt_q} <= 8'h00;
      end
      if (wr_cmd && pwdata_i[CLE_CMD_CLRABT]) begin
        abort_q <= 1'b0;
      end
      if (cnt_q == 7'h00 && !rub_open_q) begin
        video_q <= ctrl_q[CLE_CTRL_VIDEO];
      end
      unique case (state_q)
        CLE_IDLE: begin
          seq_i_q <= 2'h0;
          force_q <= 1'b0;
          if (prm_q) begin
            prm_q <= 1'b0;
            discard_q <= 1'b0;
            {ready_q, reprompt_q, rub_open_q} <= 3'h0;
            cnt_q <= 7'h00;
            {cmt_v_q, ctl_cnt_q} <= 8'h00;
            for (int i = 0; i < 3; i++) begin
              seq_q[i] <= '{caret: 1'b0, code: CLE_CH_GT};
            end
            seq_n_q <= 2'h3;
            state_q <= CLE_ECHO;
          end else if (txp_q) begin
            txp_q <= 1'b0;
            seq_q[0] <= '{caret: 1'b0, code: txb_q};
            seq_n_q <= 2'h1;
            state_q <= CLE_ECHO;
          end else if (kabort) begin
            seq_q[0] <= '{caret: 1'b1, code: CLE_CTL_C};
            seq_n_q <= 2'h1;
            force_q <= 1'b1;
            discard_q <= 1'b0;
            abort_q <= 1'b1;
            {ready_q, rub_open_q} <= 2'h0;
            cnt_q <= 7'h00;
            {cmt_v_q, ctl_cnt_q} <= 8'h00;
            state_q <= CLE_ECHO;
          end else if (kedit) begin
            if (pend_c_q == CLE_CH_CR) begin
              // Trailing space dropped; only one can be stored
              if (cnt_q != 7'h00 && cnt_q <= CLE_LINE_MAX
                  && line_q[cnt_q - 7'h01] == CLE_CH_SP) begin
                cnt_q <= cnt_q - 7'h01;
              end
              seq_q[0] <= '{caret: 1'b0, code: CLE_CH_BSL};
              seq_q[1] <= '{caret: 1'b0, code: CLE_CH_CR};
              seq_q[2] <= '{caret: 1'b0, code: CLE_CH_LF};
              seq_i_q <= rub_open_q ? 2'h0 : 2'h1;
              seq_n_q <= 2'h3;
              rub_open_q <= 1'b0;
              ready_q <= 1'b1;
              null_q <= cnt_q == 7'h00;
              long_q <= cnt_q > CLE_LINE_MAX;
              bad_q <= ctl_cnt_q != 7'h00;
              state_q <= CLE_ECHO;
            end else if (pend_c_q == CLE_CH_DEL) begin
              if (cnt_q != 7'h00) begin
                cnt_q <= cnt_q - 7'h01;
                if (cmt_v_q && cmt_q == cnt_q - 7'h01) begin
                  cmt_v_q <= 1'b0;
                end else if (!cmt_v_q && cle_is_ctl(rem_c)) begin
                  ctl_cnt_q <= ctl_cnt_q - 7'h01;
                end
                if (video_q) begin
                  seq_q[0] <= '{caret: 1'b0, code: CLE_CH_BS};
                  seq_q[1] <= '{caret: 1'b0, code: CLE_CH_SP};
                  seq_q[2] <= '{caret: 1'b0, code: CLE_CH_BS};
                  seq_n_q <= 2'h3;
                end else begin
                  seq_q[0] <= '{caret: 1'b0, code: CLE_CH_BSL};
                  seq_q[1] <= '{caret: cle_is_ctl(rem_c), code: rem_c};
                  seq_i_q <= rub_open_q ? 2'h1 : 2'h0;
                  seq_n_q <= 2'h2;
                  rub_open_q <= 1'b1;
                end
                state_q <= CLE_ECHO;
              end
            end else if (pend_c_q == CLE_CTL_U) begin
              seq_q[0] <= '{caret: 1'b1, code: CLE_CTL_U};
              seq_q[1] <= '{caret: 1'b0, code: CLE_CH_CR};
              seq_n_q <= 2'h2;
              cnt_q <= 7'h00;
              {cmt_v_q, ctl_cnt_q} <= 8'h00;
              rub_open_q <= 1'b0;
              reprompt_q <= 1'b1;
              state_q <= CLE_ECHO;
            end else if (pend_c_q == CLE_CTL_R) begin
              seq_q[0] <= '{caret: 1'b0, code: CLE_CH_CR};
              seq_q[1] <= '{caret: 1'b0, code: CLE_CH_LF};
              seq_n_q <= 2'h2;
              rub_open_q <= 1'b0;
              retype_q <= 1'b1;
              ridx_q <= 7'h00;
              state_q <= CLE_ECHO;
            end else if (pend_c_q == CLE_CTL_O) begin
              discard_q <= !discard_q;
              if (!discard_q) begin
                seq_q[0] <= '{caret: 1'b1, code: CLE_CTL_O};
                seq_q[1] <= '{caret: 1'b0, code: CLE_CH_CR};
                seq_n_q <= 2'h2;
                force_q <= 1'b1;
                state_q <= CLE_ECHO;
              end
            end else if (pend_c_q == CLE_CH_SP || pend_c_q == CLE_CH_TAB) begin
              // Leading and repeated blanks are not stored or echoed
              if (cnt_q != 7'h00 && cnt_q <= CLE_LINE_MAX
                  && line_q[cnt_q - 7'h01] != CLE_CH_SP) begin
                if (cnt_q < CLE_LINE_MAX) begin
                  line_q[cnt_q] <= CLE_CH_SP;
                end
                cnt_q <= cnt_q + 7'h01;
                seq_q[0] <= '{caret: 1'b0, code: CLE_CH_BSL};
                seq_q[1] <= '{caret: 1'b0, code: CLE_CH_SP};
                seq_i_q <= rub_open_q ? 2'h0 : 2'h1;
                seq_n_q <= 2'h2;
                rub_open_q <= 1'b0;
                state_q <= CLE_ECHO;
              end
            end else begin
              if (cnt_q < CLE_LINE_MAX) begin
                line_q[cnt_q] <= pend_c_q;
              end
              if (cnt_q != CLE_CNT_SAT) begin
                cnt_q <= cnt_q + 7'h01;
              end
              if (pend_c_q == CLE_CH_BANG && !cmt_v_q) begin
                cmt_v_q <= 1'b1;
                cmt_q <= cnt_q;
              end
              if (cle_is_ctl(pend_c_q) && !cmt_v_q) begin
                ctl_cnt_q <= ctl_cnt_q + 7'h01;
              end
              seq_q[0] <= '{caret: 1'b0, code: CLE_CH_BSL};
              seq_q[1] <= '{caret: cle_is_ctl(pend_c_q), code: pend_c_q};
              seq_i_q <= rub_open_q ? 2'h0 : 2'h1;
              seq_n_q <= 2'h2;
              rub_open_q <= 1'b0;
              state_q <= CLE_ECHO;
            end
          end
        end
        CLE_ECHO: begin
          if (seq_i_q == seq_n_q) begin
            state_q <= (retype_q && cnt_q != 7'h00) ? CLE_RETYPE : CLE_IDLE;
            retype_q <= 1'b0;
          end else if (adv) begin
            seq_i_q <= seq_i_q + 2'h1;
          end
        end
        CLE_RETYPE: begin
          if (ridx_q == rlim) begin
            state_q <= CLE_IDLE;
          end else if (adv) begin
            ridx_q <= ridx_q + 7'h01;
          end
        end
      endcase
    end
  end

  cle_emit u_emit (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(em_valid),
    .in_glyph_i(em_g),
    .in_ready_o(em_ready),
    .hold_i(stop_q),
    .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i)
  );

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign halt_o = halt_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  line_close_a: assert property (kedit && pend_c_q == CLE_CH_CR |=> ready_q
    && state_q == CLE_ECHO && seq_n_q == 2'h3 && seq_q[2].code == CLE_CH_LF)
    else $error("CR did not close the line with CR LF");
  null_cmd_a: assert property (kedit && pend_c_q == CLE_CH_CR && cnt_q == 7'h00
    |=> null_q && ready_q) else $error("empty line not flagged null");
  rub_hard_a: assert property (kedit && pend_c_q == CLE_CH_DEL && cnt_q != 7'h00
    && !video_q && !rub_open_q |=> seq_i_q == 2'h0 && seq_q[0].code == CLE_CH_BSL
    && rub_open_q) else $error("hardcopy rubout missing backslash");
  rub_video_a: assert property (kedit && pend_c_q == CLE_CH_DEL && cnt_q != 7'h00
    && video_q |=> seq_q[0].code == CLE_CH_BS && seq_n_q == 2'h3
    && cnt_q == $past(cnt_q) - 7'h01) else $error("video rubout not erased");
  rub_empty_a: assert property (kedit && pend_c_q == CLE_CH_DEL && cnt_q == 7'h00
    |=> cnt_q == 7'h00 && state_q == CLE_IDLE) else $error("rubout on empty line acted");
  abort_line_a: assert property (kabort |=> abort_q && cnt_q == 7'h00
    && force_q && seq_q[0].caret && seq_q[0].code == CLE_CTL_C)
    else $error("abort did not echo caret-C and clear line");
  stop_cancel_a: assert property (rx_valid_i && !rx_break_i && rx_data_i == CLE_CTL_C
    && !ctrl_q[CLE_CTRL_BINLD] |=> !stop_q) else $error("ctrl-C left output stopped");
  discard_on_a: assert property (kedit && pend_c_q == CLE_CTL_O && !discard_q
    |=> discard_q && force_q && seq_n_q == 2'h2) else $error("ctrl-O echo wrong");
  prompt_on_a: assert property (state_q == CLE_IDLE && prm_q |=> !discard_q
    && state_q == CLE_ECHO) else $error("prompt kept discard");
  stop_hold_a: assert property ($rose(tx_valid_o) |-> !$past(stop_q))
    else $error("byte sent while stopped");
  halt_pulse_a: assert property (khalt && ctrl_q[CLE_CTRL_HALTEN]
    |=> halt_o && !ctrl_q[CLE_CTRL_PROGIO] ##1 !halt_o) else $error("halt not one pulse");
  long_line_a: assert property (kedit && pend_c_q == CLE_CH_CR && cnt_q > CLE_LINE_MAX
    |=> long_q) else $error("over-long line not flagged");
endmodule // cle_editor
`default_nettype wire

// ---- bench/cle_term.sv ----
// Terminal model: slow receiver of echo bytes, typist of characters
`timescale 1ns/100ps
`default_nettype none
module cle_term (
  // Clock
  input wire logic sys_clk_i,
  // Echo from the editor
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  // Keyboard to the editor
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_break_o
);
  logic [7:0] log_q[$];
  logic [1:0] cnt_q = 2'h0;
  initial begin
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_break_o = 1'b0;
    rx_data_o = 8'hFF;
  end
  // Ready one cycle in four, so every echo byte after the first of a run meets a stall
  always @(posedge sys_clk_i) begin
    cnt_q <= cnt_q + 2'h1;
    tx_ready_o <= (cnt_q == 2'h2);
    if (tx_valid_i && tx_ready_o) log_q.push_back(tx_data_i);
  end
  // Called just after a rising edge; data is scrambled once the pulse ends
  task automatic send(input logic [7:0] c, input logic b);
    rx_valid_o <= !b;
    rx_break_o <= b;
    rx_data_o <= c;
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b0;
    rx_break_o <= 1'b0;
    rx_data_o <= ~c;
  endtask
endmodule // cle_term
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the console line editor
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cle_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic prdy, perr, err, txv, trdy, rxv, brk, halt;
  logic [7:0] txd, rxd;
  int errors = 0, total_checks = 0, halts = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (halt === 1'b1) halts++;
  cle_editor u_cle_editor (.sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .rx_valid_i(rxv), .rx_data_i(rxd),
    .rx_break_i(brk), .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(trdy),
    .halt_o(halt));
  cle_term u_cle_term (.sys_clk_i(clk), .tx_valid_i(txv), .tx_data_i(txd),
    .tx_ready_o(trdy), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_break_o(brk));
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pen <= 0;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 0;
    pen <= 0;
    // Idle edge so the next request never reassigns psel in this step
    @(posedge clk);
  endtask
  // Generous gap per key: a caret pair through the slow terminal fits in it
  task automatic tp(input string s, input logic b = 0);
    foreach (s[i]) begin
      u_cle_term.send(s[i], b);
      repeat (40) @(posedge clk);
    end
  endtask
  task automatic ex(input string s);
    chk(u_cle_term.log_q.size(), s.len());
    foreach (s[i]) if (i < u_cle_term.log_q.size()) chk(u_cle_term.log_q[i], s[i]);
    u_cle_term.log_q.delete();
  endtask
  task automatic st(input int b, input logic v);
    apb(0, CLE_REG_STAT, 0);
    chk(rd[b], v);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    apb(0, CLE_REG_CTRL, 0); chk(rd, 0);
    apb(0, 12'h800, 0); chk(err, 1);
    apb(1, CLE_REG_CMD, 1); tp(""); repeat (40) @(posedge clk); ex(">>>");
    tp("AB\177\177C\015"); ex("AB\\BA\\C\015\n");
    apb(0, CLE_REG_STAT, 0); chk(rd & 32'h7F0001, 32'h10001);
    apb(0, CLE_REG_LINE, 0); chk(rd[7:0], 8'h43);
    apb(1, CLE_REG_CMD, 8); tp("\177\015"); ex("\015\n");
    st(1, 1);
    apb(1, CLE_REG_CMD, 8); tp("\007\177\015"); ex("^G\\^G\\\015\n");
    $display("test editing done");
    apb(1, CLE_REG_CMD, 8); tp("\017X"); ex("^O\015");
    st(5, 1);
    tp("\003"); ex("^C");
    st(5, 0);
    st(4, 1);
    tp("\017\017"); ex("^O\015");
    tp("\017"); apb(1, CLE_REG_CMD, 1); repeat (40) @(posedge clk);
    ex("^O\015>>>");
    apb(1, CLE_REG_CMD, 4); tp("\023Z"); ex("");
    st(6, 1);
    tp("\021\021"); ex("Z");
    apb(1, CLE_REG_CTRL, 8); tp("\003"); ex("");
    st(4, 0);
    apb(1, CLE_REG_CTRL, 0); tp("\025"); ex("^U\015");
    st(7, 1);
    $display("test flow done");
    apb(1, CLE_REG_CTRL, 1); tp("K\177M\022"); ex("K\010 \010M\015\nM");
    tp("\025"); ex("^U\015");
    apb(1, CLE_REG_CTRL, 0); tp(" ", 1); ex("^C");
    apb(1, CLE_REG_CTRL, 6); tp(" ", 1); chk(halts, 1);
    apb(0, CLE_REG_CTRL, 0); chk(rd, 2);
    apb(1, CLE_REG_CTRL, 4); tp(" ", 1); chk(halts, 1);
    ex("");
    $display("test video and break done");
    apb(1, CLE_REG_CTRL, 0); apb(1, CLE_REG_CMD, 8);
    tp("  a\tb  \015"); ex("a b \015\n");
    apb(0, CLE_REG_STAT, 0); chk(rd & 32'h7F0000, 32'h30000);
    apb(0, CLE_REG_LINE + 12'h004, 0); chk(rd[7:0], 8'h20);
    apb(1, CLE_REG_CMD, 8); tp("\001\015"); ex("^A\015\n"); st(3, 1);
    apb(1, CLE_REG_CMD, 8); tp("!\001\015"); ex("!^A\015\n"); st(3, 0);
    apb(1, CLE_REG_CMD, 8); tp("\017"); apb(1, CLE_REG_TXD, 32'h41);
    repeat (10) @(posedge clk);
    apb(1, CLE_REG_CMD, 2); st(5, 0); ex("^O\015");
    apb(1, CLE_REG_TXD, 32'h42); repeat (40) @(posedge clk); ex("B");
    tp("\023PQR"); st(8, 1); tp("\021"); ex("PQ");
    apb(1, CLE_REG_CMD, 16); st(8, 0);
    apb(1, CLE_REG_CMD, 8); repeat (81) tp("x");
    chk(u_cle_term.log_q.size(), 81); u_cle_term.log_q.delete();
    tp("\015"); ex("\015\n"); st(2, 1);
    $display("test lines and output done");
    results();
  end
endmodule // tb
`default_nettype wire
